// ---- rtl/adc_conversion_control.sv ----
// adc_conversion_control: digital control of a successive-approximation converter
// assumes: one 100 MHz clock, software on a plain strobe port, analog result on resultIn
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module adc_conversion_control
    import adc_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic hwTriggerInput,
    input wire logic [11:0] resultIn,
    output logic convIrq,
    output logic eventIrq,
    output logic converterPowered,
    output logic sampleEnable,
    output logic [1:0] selectKind,
    output logic [4:0] selectInput
);
    typedef struct packed
    {
        logic [7:0] ctrl;
        logic trigSel;
        logic cmpEn;
        logic cmpGe;
        logic [11:0] cmpValue;
        logic [11:0] result;
        logic continuous;
        logic trigSync1;
        logic trigSync2;
        logic trigPrev;
        logic armed;
        logic [NUM_EV-1:0] evStatus;
        logic [NUM_EV-1:0] evMask;
        logic [7:0] rdata;
        logic convIrq;
        logic eventIrq;
        logic powered;
        logic sampling;
        logic [1:0] kind;
        logic [4:0] index;
    } ctrl_reg_t;

    ctrl_reg_t r;
    ctrl_reg_t next_r;

    adc_seq_if seqBus();
    sel_kind_t decKind;
    logic [4:0] decIndex;
    logic decReserved;

    // compare condition, selected polarity
    function automatic logic compareTrue(input logic [11:0] res, input logic [11:0] val,
                                         input logic ge);
        compareTrue = ge ? (res >= val) : (res < val);
    endfunction

    // write-one-to-clear with set winning over clear
    function automatic logic [NUM_EV-1:0] stickyUpdate(input logic [NUM_EV-1:0] cur,
                                                      input logic [NUM_EV-1:0] set,
                                                      input logic [NUM_EV-1:0] clr);
        stickyUpdate = (cur & ~clr) | set;
    endfunction

    adc_chan_decode u_decode
    (
        .code(r.ctrl[CH_HI:CH_LO]),
        .kind(decKind),
        .inputIndex(decIndex),
        .reserved(decReserved)
    );

    adc_conv_seq u_seq
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .bus(seqBus.seq)
    );

    // combinational start and abort decisions
    logic ctrlWrite;
    logic writeDisables;
    logic trigEdge;
    logic hwStart;
    logic swStart;
    logic repeatStart;
    logic convFinished;
    logic doneSet;
    logic doneClear;

    always_comb
    begin
        ctrlWrite = regWrite && (regAddr == OFF_CTRL);
        writeDisables = (regWdata[CH_HI:CH_LO] == CH_DISABLED);
        // edge taken only from the second sync stage onward
        trigEdge = r.trigSync2 && !r.trigPrev;
        // trigger only counts when hardware triggering is picked and nothing runs
        hwStart = r.trigSel && trigEdge && !seqBus.busy && r.armed && !ctrlWrite;
        // trigger type comes from the trigger register, never from the written control byte
        swStart = ctrlWrite && !writeDisables
                  && !r.trigSel;
        convFinished = seqBus.done;
        // continuous mode reloads on its own, unless disabled in the meantime
        repeatStart = convFinished && r.continuous && !ctrlWrite
                      && (r.ctrl[CH_HI:CH_LO] != CH_DISABLED);
        doneSet = convFinished && (!r.cmpEn
                  || compareTrue(resultIn, r.cmpValue, r.cmpGe));
        doneClear = ctrlWrite || (regRead && (regAddr == OFF_RESL));
    end

    assign seqBus.abort = ctrlWrite;
    assign seqBus.start = swStart || hwStart || repeatStart;

    // register file, flags and conversion bookkeeping
    always_comb
    begin
        logic [NUM_EV-1:0] evSet;
        logic [NUM_EV-1:0] evClr;
        evSet = '0;
        evClr = '0;
        next_r = r;
        // two-stage synchroniser then an edge register
        next_r.trigSync1 = hwTriggerInput;
        next_r.trigSync2 = r.trigSync1;
        next_r.trigPrev = r.trigSync2;

        if (regWrite)
        begin
            case (regAddr)
                OFF_CTRL:
                begin
                    next_r.ctrl[BIT_IEN] = regWdata[BIT_IEN];
                    next_r.ctrl[BIT_CONT] = regWdata[BIT_CONT];
                    next_r.ctrl[CH_HI:CH_LO] = regWdata[CH_HI:CH_LO];
                    next_r.continuous = regWdata[BIT_CONT] && !writeDisables;
                    // a hardware-triggered setup waits for the next edge
                    next_r.armed = !writeDisables;
                    if (seqBus.busy)
                        evSet[EV_ABORT] = 1'b1;
                end
                OFF_TRIG:
                begin
                    next_r.trigSel = regWdata[BIT_TRIGSEL];
                    next_r.cmpEn = regWdata[BIT_CMPEN];
                    next_r.cmpGe = regWdata[BIT_CMPGE];
                end
                OFF_CMPV: next_r.cmpValue[7:0] = regWdata;
                OFF_CMPH: next_r.cmpValue[11:8] = regWdata[3:0];
                OFF_IRQS: evClr = regWdata[NUM_EV-1:0];
                OFF_IRQM: next_r.evMask = regWdata[NUM_EV-1:0];
                default: ;
            endcase
        end

        // result is only kept when the done flag would be set
        if (doneSet)
            next_r.result = resultIn;
        // set wins over any clear in the same cycle
        if (doneClear)
            next_r.ctrl[BIT_DONE] = 1'b0;
        if (doneSet)
        begin
            next_r.ctrl[BIT_DONE] = 1'b1;
            evSet[EV_DONE] = 1'b1;
        end
        if (hwStart)
        begin
            evSet[EV_TRIG] = 1'b1;
            // single mode takes one conversion per edge
            next_r.continuous = r.ctrl[BIT_CONT];
        end
        next_r.evStatus = stickyUpdate(r.evStatus, evSet, evClr);

        // interrupt level follows flag and enable
        next_r.convIrq = next_r.ctrl[BIT_DONE] && next_r.ctrl[BIT_IEN];
        next_r.eventIrq = |(next_r.evStatus & next_r.evMask);

        // power: only while converting, or in a continuous run
        next_r.sampling = seqBus.start || (seqBus.busy && !seqBus.abort && !convFinished);
        next_r.powered = next_r.sampling
                         || (r.continuous && next_r.ctrl[CH_HI:CH_LO] != CH_DISABLED);
        if (next_r.ctrl[CH_HI:CH_LO] == CH_DISABLED)
            next_r.powered = 1'b0;
        next_r.kind = decKind;
        next_r.index = (decKind == SEL_INPUT) ? decIndex : 5'h00;
        if (!next_r.powered || decReserved)
            next_r.kind = SEL_NONE;

        // read data in the cycle after the strobe only
        next_r.rdata = 8'h00;
        if (regRead)
        begin
            case (regAddr)
                OFF_CTRL: next_r.rdata = r.ctrl;
                OFF_TRIG: next_r.rdata = {1'b0, r.trigSel, r.cmpEn, r.cmpGe, 4'h0};
                OFF_STAT: next_r.rdata = {seqBus.busy, 5'h00, r.powered, r.continuous};
                OFF_CMPV: next_r.rdata = r.cmpValue[7:0];
                OFF_CMPH: next_r.rdata = {4'h0, r.cmpValue[11:8]};
                OFF_RESL: next_r.rdata = r.result[7:0];
                OFF_RESH: next_r.rdata = {4'h0, r.result[11:8]};
                OFF_IRQS: next_r.rdata = {5'h00, r.evStatus};
                OFF_IRQM: next_r.rdata = {5'h00, r.evMask};
                default: next_r.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r <= '0;
            r.ctrl <= CTRL_RESET;
            r.kind <= SEL_NONE;
        end
        else
            r <= next_r;
    end

    // outputs straight from flip-flops
    assign regRdata = r.rdata;
    assign convIrq = r.convIrq;
    assign eventIrq = r.eventIrq;
    assign converterPowered = r.powered;
    assign sampleEnable = r.sampling;
    assign selectKind = r.kind;
    assign selectInput = r.index;
endmodule // adc_conversion_control

// ---- rtl/adc_ctrl_pkg.sv ----
// adc_ctrl_pkg: register offsets, field layout, reset values and timing for the converter control
// assumes: shared by the control top, the channel decoder and the conversion sequencer
package adc_ctrl_pkg;
    // register byte offsets (8-bit data on a plain port)
    localparam logic [3:0] OFF_CTRL = 4'h0;    // conversion_control_reg
    localparam logic [3:0] OFF_TRIG = 4'h1;    // trigger and compare control
    localparam logic [3:0] OFF_STAT = 4'h2;    // activity status
    localparam logic [3:0] OFF_CMPV = 4'h3;    // compare value, low byte
    localparam logic [3:0] OFF_CMPH = 4'h4;    // compare value, high nibble
    localparam logic [3:0] OFF_RESL = 4'h5;    // result_low_reg
    localparam logic [3:0] OFF_RESH = 4'h6;    // result high nibble
    localparam logic [3:0] OFF_IRQS = 4'h7;    // sticky event status, write one to clear
    localparam logic [3:0] OFF_IRQM = 4'h8;    // event mask
    // conversion_control_reg fields
    localparam int BIT_DONE = 7;
    localparam int BIT_IEN = 6;
    localparam int BIT_CONT = 5;
    localparam int CH_HI = 4;
    localparam int CH_LO = 0;
    // trigger register fields
    localparam int BIT_TRIGSEL = 6;
    localparam int BIT_CMPEN = 5;
    localparam int BIT_CMPGE = 4;
    // event bits: 0 done, 1 abort, 2 hardware trigger taken
    localparam int EV_DONE = 0;
    localparam int EV_ABORT = 1;
    localparam int EV_TRIG = 2;
    localparam int NUM_EV = 3;
    // channel codes
    localparam logic [4:0] CH_LAST_INPUT = 5'h1b;
    localparam logic [4:0] CH_RESERVED = 5'h1c;
    localparam logic [4:0] CH_REF_HIGH = 5'h1d;
    localparam logic [4:0] CH_REF_LOW = 5'h1e;
    localparam logic [4:0] CH_DISABLED = 5'h1f;
    localparam logic [7:0] CTRL_RESET = 8'h1f;  // reset to the disabled code
    // conversion time, in ns, and the derived cycle count at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 2000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);

    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'b00,
        SEQ_CONVERT = 2'b01,
        SEQ_FINISH = 2'b10
    } seq_state_t;

    typedef enum logic [1:0]
    {
        SEL_INPUT = 2'b00,
        SEL_REF_HIGH = 2'b01,
        SEL_REF_LOW = 2'b10,
        SEL_NONE = 2'b11
    } sel_kind_t;
endpackage

// ---- rtl/adc_seq_if.sv ----
// adc_seq_if: bundle between the control top and the conversion sequencer
// assumes: one clock domain, start and abort decoded combinationally, busy and done from sequencer flip-flops
`timescale 1ns/1ps
interface adc_seq_if;
    logic start;
    logic abort;
    logic busy;
    logic done;
    modport ctrl (output start, output abort, input busy, input done);
    modport seq (input start, input abort, output busy, output done);
endinterface // adc_seq_if

// ---- rtl/adc_chan_decode.sv ----
// adc_chan_decode: turns the 5-bit channel code into an analog mux selection
// assumes: pure combinational use, code held in a register of the caller
`timescale 1ns/1ps
module adc_chan_decode
    import adc_ctrl_pkg::*;
(
    input wire logic [4:0] code,
    output sel_kind_t kind,
    output logic [4:0] inputIndex,
    output logic reserved
);
    // codes up to the last input pick a pin, then the two references
    always_comb
    begin
        inputIndex = code;
        reserved = 1'b0;
        if (code <= CH_LAST_INPUT)
            kind = SEL_INPUT;
        else if (code == CH_REF_HIGH)
            kind = SEL_REF_HIGH;
        else if (code == CH_REF_LOW)
            kind = SEL_REF_LOW;
        else
        begin
            kind = SEL_NONE;
            reserved = (code == CH_RESERVED);
        end
    end
endmodule // adc_chan_decode

// ---- rtl/adc_conv_seq.sv ----
// adc_conv_seq: times one conversion and reports its completion
// assumes: start and abort are one-cycle pulses; a start in the abort cycle restarts the conversion
`timescale 1ns/1ps
module adc_conv_seq
    import adc_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    adc_seq_if.seq bus
);
    typedef struct packed
    {
        seq_state_t state;
        logic [7:0] count;
        logic done;
    } seq_reg_t;

    seq_reg_t r;
    seq_reg_t next_r;

    assign bus.busy = (r.state != SEQ_IDLE);
    assign bus.done = r.done;

    // count out the conversion; an abort drops it on the spot
    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        case (r.state)
            SEQ_IDLE:
            begin
                if (bus.start)
                begin
                    next_r.state = SEQ_CONVERT;
                    next_r.count = '0;
                end
            end
            SEQ_CONVERT:
            begin
                if (r.count == CONV_LAST)
                    next_r.state = SEQ_FINISH;
                else
                    next_r.count = r.count + 8'h01;
            end
            SEQ_FINISH:
            begin
                next_r.done = 1'b1;
                next_r.state = SEQ_IDLE;
            end
            default:
                next_r.state = SEQ_IDLE;
        endcase
        if (bus.abort)
        begin
            // restart allowed in the abort cycle itself
            next_r.done = 1'b0;
            next_r.count = '0;
            next_r.state = bus.start ? SEQ_CONVERT : SEQ_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            r <= '{state: SEQ_IDLE, count: 8'h00, done: 1'b0};
        else
            r <= next_r;
    end
endmodule // adc_conv_seq

// ---- testbench/adc_conversion_control_props.sv ----
// adc_conversion_control_props: port-level assertions for the converter control
// assumes: bound onto adc_conversion_control, one clock, software on the plain strobe port
`timescale 1ns/1ps
module adc_conversion_control_props
    import adc_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic hwTriggerInput,
    input wire logic [11:0] resultIn,
    input wire logic convIrq,
    input wire logic eventIrq,
    input wire logic converterPowered,
    input wire logic sampleEnable,
    input wire logic [1:0] selectKind,
    input wire logic [4:0] selectInput
);
    logic ctrlWr;
    logic [7:0] ctrlShadow;
    logic [7:0] trigShadow;
    logic [3:0] sinceWr;

    assign ctrlWr = regWrite && regAddr == OFF_CTRL;

    // shadow of the software settings; age saturates so old writes stop mattering
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrlShadow <= CTRL_RESET;
            trigShadow <= 8'h00;
            sinceWr <= 4'hf;
        end
        else
        begin
            if (ctrlWr)
                ctrlShadow <= regWdata;
            if (regWrite && regAddr == OFF_TRIG)
                trigShadow <= regWdata;
            sinceWr <= ctrlWr ? 4'h0 : sinceWr + 4'(sinceWr != 4'hf);
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    start_on_write_a: assert property (
        ctrlWr && regWdata[4:0] != CH_DISABLED && !trigShadow[BIT_TRIGSEL] |-> ##[1:3] sampleEnable)
        else $error("no conversion after control write");
    disable_stops_a: assert property (
        ctrlWr && regWdata[4:0] == CH_DISABLED
        |-> ##3 (!sampleEnable && selectKind == 2'd3 && !converterPowered) [*8])
        else $error("converter active after disable code");
    irq_clear_a: assert property (
        ctrlWr |-> ##2 !convIrq)
        else $error("done interrupt kept after control write");
    irq_needs_enable_a: assert property (
        convIrq |-> ctrlShadow[BIT_IEN] || sinceWr < 4'd3)
        else $error("done interrupt without enable");
    irq_on_done_a: assert property (
        $fell(sampleEnable) && sinceWr == 4'hf && ctrlShadow[BIT_IEN] && !trigShadow[BIT_CMPEN]
        |-> ##[1:3] convIrq)
        else $error("no done interrupt after conversion");
    power_down_a: assert property (
        $fell(sampleEnable) && sinceWr == 4'hf && !ctrlShadow[BIT_CONT] |-> ##[0:3] !converterPowered)
        else $error("converter stays powered after single conversion");
    repeat_cont_a: assert property (
        $fell(sampleEnable) && sinceWr == 4'hf |-> !ctrlShadow[BIT_CONT])
        else $error("continuous conversions did not repeat");
    chan_map_a: assert property (
        sampleEnable && sinceWr == 4'hf && ctrlShadow[4:0] <= CH_LAST_INPUT
        |-> selectKind == 2'd0 && selectInput == ctrlShadow[4:0])
        else $error("input selection differs from channel code");
    rdata_idle_a: assert property (
        !$past(regRead) |-> regRdata == 8'h00)
        else $error("read data outside its cycle");
endmodule // adc_conversion_control_props

bind adc_conversion_control adc_conversion_control_props u_props (
    .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .hwTriggerInput(hwTriggerInput), .resultIn(resultIn), .convIrq(convIrq),
    .eventIrq(eventIrq), .converterPowered(converterPowered), .sampleEnable(sampleEnable),
    .selectKind(selectKind), .selectInput(selectInput));

// ---- testbench/adc_conversion_control_tb.sv ----
// adc_conversion_control_tb: self-checking bench for the converter control
// assumes: package and rtl compiled first, checker bound from its own file
`timescale 1ns/1ps
module adc_conversion_control_tb
    import adc_ctrl_pkg::*;
;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic hwTriggerInput = 1'b0;
    logic [11:0] resultIn = 12'h000;
    logic [7:0] regRdata;
    logic convIrq, eventIrq, converterPowered, sampleEnable;
    logic [1:0] selectKind;
    logic [4:0] selectInput;
    int badCount = 0;
    int checks = 0;
    int rise;
    int fin;
    int unsigned seed = 66;
    logic [7:0] got;
    logic [11:0] res, cv, last;
    logic expDone;
    logic [4:0] codes [4] = '{5'h00, CH_LAST_INPUT, CH_REF_HIGH, CH_REF_LOW};
    int kinds [4] = '{0, 0, 1, 2};

    adc_conversion_control u_adc_conversion_control (.core_clk(core_clk), .resetn(resetn),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .hwTriggerInput(hwTriggerInput), .resultIn(resultIn),
        .convIrq(convIrq), .eventIrq(eventIrq), .converterPowered(converterPowered),
        .sampleEnable(sampleEnable), .selectKind(selectKind), .selectInput(selectInput));

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    function automatic logic [11:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[11:0];
    endfunction

    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] seen);
        checks++;
        if (seen !== exp)
        begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // bus cycles: strobe for one edge, then settle one step past the edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        got = regRdata;
    endtask

    task automatic waitSe(input logic lvl, input int lim);
        int n;
        n = 0;
        while (sampleEnable !== lvl && n < lim)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("sampleEnable", 12'(lvl), 12'(sampleEnable));
    endtask

    task automatic conv(input logic [7:0] c);
        wr(OFF_CTRL, c);
        waitSe(1'b1, 5);
        waitSe(1'b0, CONV_CYCLES + 10);
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    // counts starts (rise) and completions (fin); back-to-back runs keep sampleEnable high,
    // so a completion is seen as the done interrupt, then cleared by a low result read;
    // the trigger is held 3 cycles so the synchroniser sees it
    task automatic runs(input int n, input logic trig);
        logic prev;
        logic clr;
        prev = sampleEnable;
        clr = 1'b0;
        rise = 0;
        fin = 0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge core_clk);
            hwTriggerInput <= trig && i < 3;
            regAddr <= OFF_RESL;
            regRead <= clr;
            #1;
            if (sampleEnable && !prev)
                rise++;
            prev = sampleEnable;
            clr = convIrq && !clr;
            if (clr)
                fin++;
        end
        // drop a read strobe left high by the last pass
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        rd(OFF_CTRL);
        chk("ctrl reset", 12'(CTRL_RESET), 12'(got));
        chk("kind idle", 12'd3, 12'(selectKind));
        wr(4'hf, 8'hff);
        rd(4'hf);
        chk("unmapped", 12'h000, 12'(got));
        $display("test reset done");
        // compare off, then both polarities, equal values hit the boundary
        for (int m = 0; m < 5; m++)
        begin
            res = xs();
            cv = (m < 3) ? res : xs();
            expDone = (m == 0) || (m[0] ? res >= cv : res < cv);
            if (expDone)
                last = res;
            resultIn <= res;
            wr(OFF_CMPV, cv[7:0]);
            wr(OFF_CMPH, {4'h0, cv[11:8]});
            wr(OFF_TRIG, (m == 0) ? 8'h00 : {3'b001, m[0], 4'h0});
            conv(8'h45);
            rd(OFF_CTRL);
            chk("done flag", {4'h0, expDone, 7'h45}, 12'(got));
            chk("done irq", 12'(expDone), 12'(convIrq));
            chk("powered", 12'h000, 12'(converterPowered));
            rd(OFF_RESL);
            chk("result low", 12'(last[7:0]), 12'(got));
            repeat (2) @(posedge core_clk);
            #1;
            chk("irq cleared", 12'h000, 12'(convIrq));
        end
        $display("test compare done");
        // interrupt enabled so each completion of a run can be counted
        wr(OFF_TRIG, 8'h00);
        wr(OFF_CTRL, 8'h65);
        runs(3 * CONV_CYCLES + 50, 1'b0);
        chk("repeat runs", 12'd1, 12'(fin >= 2));
        wr(OFF_CTRL, 8'h7f);
        runs(2 * CONV_CYCLES, 1'b0);
        chk("runs after stop", 12'd0, 12'(rise + fin));
        $display("test continuous done");
        wr(OFF_TRIG, 8'h40);
        wr(OFF_CTRL, 8'h45);
        runs(20, 1'b0);
        chk("no start on write", 12'd0, 12'(rise));
        runs(30, 1'b1);
        chk("trigger start", 12'd1, 12'(rise));
        runs(2 * CONV_CYCLES, 1'b1);
        chk("busy trigger", 12'd0, 12'(rise));
        chk("hw single done", 12'd1, 12'(fin));
        wr(OFF_CTRL, 8'h65);
        runs(3 * CONV_CYCLES + 50, 1'b1);
        chk("hw repeat runs", 12'd1, 12'(fin >= 2));
        $display("test hardware trigger done");
        wr(OFF_TRIG, 8'h00);
        foreach (codes[i])
        begin
            wr(OFF_CTRL, {3'b000, codes[i]});
            repeat (3) @(posedge core_clk);
            #1;
            chk("kind", 12'(kinds[i]), 12'(selectKind));
            chk("input", (kinds[i] == 0) ? 12'(codes[i]) : 12'h000, 12'(selectInput));
        end
        $display("test channels done");
        // sticky events: set by a conversion, masked, cleared by writing one
        wr(OFF_CTRL, 8'h1f);
        // let the disabled code stand before the next start
        repeat (12) @(posedge core_clk);
        wr(OFF_IRQS, 8'h07);
        wr(OFF_IRQM, 8'h00);
        conv(8'h05);
        rd(OFF_IRQS);
        chk("done event", 12'h001, 12'(got));
        chk("masked irq", 12'h000, 12'(eventIrq));
        wr(OFF_IRQM, 8'h07);
        repeat (2) @(posedge core_clk);
        #1;
        chk("mask effect", 12'h001, 12'(eventIrq));
        wr(OFF_IRQS, 8'h01);
        rd(OFF_IRQS);
        chk("event cleared", 12'h000, 12'(got));
        chk("event irq low", 12'h000, 12'(eventIrq));
        $display("test events done");
        endOfTest();
    end

    // watchdog, far beyond the expected run of a few thousand cycles
    initial
    begin
        #(100 * CONV_CYCLES * 10);
        badCount++;
        endOfTest();
    end
endmodule // adc_conversion_control_tb
